/* rtl/rcac_core.sv */
// Real-time clock seconds/sub-second counters with two alarms, APB slave
// Operation
// - Seconds counter increments once per sub-second counter wrap.
// - 12-bit sub-second counter wraps all-ones to zero, steps seconds.
// - Enable cleared freezes both counters; oscillator keeps running.
// - While enabled, trim tick field increments every 32 seconds.
// - Counters run from a 32.768 kHz time base on the oscillator pin.
// - Read-window flag held high 120 us after each counter update.
// - Software may clear read-window flag; next update sets it again.
// - Unsynchronized read skips window gating; software reads twice.
// - Synchronized register write sets busy until value is transferred.
// - Busy gates counters, trim, enable; unlock gates trim, enable, osc
// - Alarm value equal seconds[19:0] sets daytime alarm flag once.
// - Daytime flag requests interrupt only with both enables set.
// - Interval counter starts at start value; wrap sets flag, reloads.
// - Interval counter advances on the untrimmed sub-second tick.
// - First interval may run up to one tick short; later ones exact.
// - Start value zero gives the longest interval.
// - One interrupt output from any enabled source.
// - Alarms wake from low-power modes when wake allow and that alarm's interrupt enable are set.
`timescale 1ns/100ps
`default_nettype none
module rcac_core (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic oscInputPin,
    input wire logic irqSystemEnable,
    input wire logic clockWakeAllow,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic clockIrqLine,
    output logic wakeRequest
);
    import rcac_pkg::*;
    logic [1:0] oscSync_r;
    logic oscPrev_r, tick_r, intRun_r, todMatchPrev_r;
    logic [TICK_DIV_W-1:0] tickDiv_r;
    logic [31:0] seconds_r, intStart_r, intCount_r;
    logic [SUB_W-1:0] subsec_r;
    logic [TOD_W-1:0] dayAlarm_r;
    logic [TRIM_W-1:0] trim_r;
    logic [TICK_W-1:0] trimTick_r;
    logic [TRIM_SEC_W-1:0] trimSec_r;
    logic [OSC_W-1:0] oscCtrl_r;
    logic enable_r, todIe_r, ssIe_r, rdyIe_r, rdEn_r, wrEn_r;
    logic todFlag_r, ssFlag_r, rdy_r;
    logic [RDY_W-1:0] rdyCnt_r;
    rcac_pend_t pend_r;
    logic [1:0] busyCnt_r;
    logic busy, access, wrAcc, secWrap, todMatch, intWrap, ctlWrite;
    // Decoder shared by read mux and write path
    function automatic logic isAddr(input logic [7:0] a, input logic [7:0] o);
        isAddr = (a == o);
    endfunction : isAddr
    assign access = psel && penable && clkEn;
    assign wrAcc = access && pwrite;
    assign busy = (pend_r.kind != WK_NONE);
    assign ctlWrite = wrAcc && isAddr(paddr, OFF_CONTROL);
    // Oscillator pin synchroniser; stage 0 feeds only stage 1
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oscSync_r <= 2'b00;
            oscPrev_r <= 1'b0;
        end else if (clkEn) begin
            oscSync_r <= {oscSync_r[0], oscInputPin};
            oscPrev_r <= oscSync_r[1];
        end
    end

    // Divide 32.768 kHz edges by 8 to a 4096 Hz tick; trim is stored only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tickDiv_r <= '0;
            tick_r <= 1'b0;
        end else if (clkEn) begin
            tick_r <= 1'b0;
            if (oscSync_r[1] && !oscPrev_r) begin
                if (tickDiv_r == TICK_DIV_W'(TICK_DIV_LAST)) begin
                    tickDiv_r <= '0;
                    tick_r <= 1'b1;
                end else begin
                    tickDiv_r <= tickDiv_r + 1'b1;
                end
            end
        end
    end
    assign secWrap = tick_r && enable_r && (subsec_r == SUB_ONES);
    // Pending synchronized write: busy until busyCnt_r reaches SYNC_CYCLES
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_r <= '0;
            busyCnt_r <= '0;
        end else if (clkEn) begin
            if (!busy && wrAcc) begin
                if (isAddr(paddr, OFF_SECONDS)) begin
                    pend_r <= '{WK_SEC, pwdata};
                end else if (isAddr(paddr, OFF_SUBSEC)) begin
                    pend_r <= '{WK_SUB, pwdata};
                end else if (isAddr(paddr, OFF_DAYALARM)
                             && (!todIe_r || !enable_r)) begin
                    pend_r <= '{WK_TOD, pwdata};
                end else if (isAddr(paddr, OFF_INTALARM)
                             && (!ssIe_r || !enable_r)) begin
                    pend_r <= '{WK_INT, pwdata};
                end else if (isAddr(paddr, OFF_TRIM) && wrEn_r) begin
                    pend_r <= '{WK_TRIM, pwdata};
                end else if (ctlWrite && wrEn_r) begin
                    pend_r <= '{WK_EN, pwdata};
                end
                busyCnt_r <= '0;
            end else if (busy) begin
                // Transfer after a short domain-crossing delay
                if (busyCnt_r == 2'(SYNC_CYCLES)) begin
                    pend_r.kind <= WK_NONE;
                end else begin
                    busyCnt_r <= busyCnt_r + 1'b1;
                end
            end
        end
    end

    // Counter and alarm value storage, written when pending completes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seconds_r <= '0;
            subsec_r <= '0;
            dayAlarm_r <= '0;
            intStart_r <= '0;
            trim_r <= '0;
            enable_r <= 1'b0;
        end else if (clkEn) begin
            if (tick_r && enable_r) begin
                subsec_r <= subsec_r + 1'b1;
                if (secWrap) begin
                    seconds_r <= seconds_r + 1'b1;
                end
            end
            if (busy && busyCnt_r == 2'(SYNC_CYCLES)) begin
                case (pend_r.kind)
                    WK_SEC: seconds_r <= pend_r.data;
                    WK_SUB: subsec_r <= pend_r.data[SUB_W-1:0];
                    WK_TOD: dayAlarm_r <= pend_r.data[TOD_W-1:0];
                    WK_INT: intStart_r <= pend_r.data;
                    WK_TRIM: trim_r <= pend_r.data[TRIM_W-1:0];
                    WK_EN: enable_r <= pend_r.data[CTL_EN];
                    default: ;
                endcase
            end
        end
    end

    // Control bits without unlock: take effect at once when not busy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            todIe_r <= 1'b0;
            ssIe_r <= 1'b0;
            rdyIe_r <= 1'b0;
            rdEn_r <= 1'b0;
            wrEn_r <= 1'b0;
            oscCtrl_r <= '0;
        end else if (clkEn) begin
            if (ctlWrite && !busy) begin
                todIe_r <= pwdata[CTL_TODIE];
                ssIe_r <= pwdata[CTL_SSIE];
                rdyIe_r <= pwdata[CTL_RDYIE];
                rdEn_r <= pwdata[CTL_RDEN];
                wrEn_r <= pwdata[CTL_WREN];
            end
            // Oscillator control skips busy, needs only unlock
            if (wrAcc && isAddr(paddr, OFF_OSCCTRL) && wrEn_r) begin
                oscCtrl_r <= pwdata[OSC_W-1:0];
            end
        end
    end

    // Trim tick field steps every 32 seconds while enabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trimSec_r <= '0;
            trimTick_r <= '0;
        end else if (clkEn && secWrap) begin
            trimSec_r <= trimSec_r + 1'b1;
            if (trimSec_r == TRIM_SEC_W'(TRIM_SECS - 1)) begin
                trimTick_r <= trimTick_r + 1'b1;
            end
        end
    end

    // Read window: counter update opens a 120 us valid slot
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdy_r <= 1'b0;
            rdyCnt_r <= '0;
        end else if (clkEn) begin
            if (tick_r && enable_r) begin
                rdy_r <= 1'b1;
                rdyCnt_r <= RDY_W'(RDY_CYCLES - 1);
            end else if (ctlWrite && !busy && !pwdata[CTL_RDY]) begin
                rdy_r <= 1'b0;
            end else if (rdyCnt_r != '0) begin
                rdyCnt_r <= rdyCnt_r - 1'b1;
            end else begin
                rdy_r <= 1'b0;
            end
        end
    end
    assign todMatch = (dayAlarm_r == seconds_r[TOD_W-1:0]);
    assign intWrap = intRun_r && tick_r && enable_r
                     && (intCount_r == ALL_ONES);
    // Interval alarm counter on untrimmed tick with auto reload
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            intCount_r <= '0;
            intRun_r <= 1'b0;
        end else if (clkEn) begin
            intRun_r <= ssIe_r;
            if (!intRun_r) begin
                intCount_r <= intStart_r;
            end else if (intWrap) begin
                intCount_r <= intStart_r;
            end else if (tick_r && enable_r) begin
                intCount_r <= intCount_r + 1'b1;
            end
        end
    end
    // Alarm flags; hardware set wins over a software clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            todFlag_r <= 1'b0;
            ssFlag_r <= 1'b0;
            todMatchPrev_r <= 1'b0;
        end else if (clkEn) begin
            todMatchPrev_r <= todMatch;
            if (todMatch && !todMatchPrev_r && enable_r) begin
                todFlag_r <= 1'b1;
            end else if (ctlWrite && !busy) begin
                todFlag_r <= pwdata[CTL_TODFLAG];
            end
            if (intWrap) begin
                ssFlag_r <= 1'b1;
            end else if (ctlWrite && !busy) begin
                ssFlag_r <= pwdata[CTL_SSFLAG];
            end
        end
    end

    // Registered interrupt and wake outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clockIrqLine <= 1'b0;
            wakeRequest <= 1'b0;
        end else if (clkEn) begin
            clockIrqLine <= irqSystemEnable
                && ((todFlag_r && todIe_r) || (ssFlag_r && ssIe_r)
                    || (rdy_r && rdyIe_r));
            wakeRequest <= clockWakeAllow
                && ((todFlag_r && todIe_r)
                    || (ssFlag_r && ssIe_r));
        end
    end

    // APB answer: zero wait, counters gated by window unless bypassed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                if (isAddr(paddr, OFF_SECONDS)) begin
                    prdata <= (rdy_r || rdEn_r) ? seconds_r : '0;
                end else if (isAddr(paddr, OFF_SUBSEC)) begin
                    prdata <= (rdy_r || rdEn_r)
                        ? {20'h00000, subsec_r} : '0;
                end else if (isAddr(paddr, OFF_DAYALARM)) begin
                    prdata <= {12'h000, dayAlarm_r};
                end else if (isAddr(paddr, OFF_INTALARM)) begin
                    prdata <= intStart_r;
                end else if (isAddr(paddr, OFF_CONTROL)) begin
                    prdata <= {16'h0000, wrEn_r, rdEn_r, 6'h00,
                        ssFlag_r, todFlag_r, rdyIe_r, rdy_r, busy,
                        ssIe_r, todIe_r, enable_r};
                end else if (isAddr(paddr, OFF_TRIM)) begin
                    prdata <= {trimTick_r, trim_r};
                end else if (isAddr(paddr, OFF_OSCCTRL)) begin
                    prdata <= {24'h000000, oscCtrl_r};
                end else begin
                    prdata <= '0;
                end
            end
        end
    end

    // Assertions
    property p_wrap_steps_seconds;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && secWrap && !busy) |=> (seconds_r == $past(seconds_r) + 1);
    endproperty
    a_wrap_steps_seconds: assert property (p_wrap_steps_seconds)
        else $error("seconds did not step on wrap");
    property p_frozen_when_off;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && !enable_r && !busy) |=> $stable(subsec_r);
    endproperty
    a_frozen_when_off: assert property (p_frozen_when_off)
        else $error("sub-second counter moved while disabled");
    property p_rdy_rise;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && tick_r && enable_r) |=> rdy_r;
    endproperty
    a_rdy_rise: assert property (p_rdy_rise)
        else $error("read window not opened after update");
    property p_rdy_holds;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && $rose(rdy_r) && rdyCnt_r > 2) |=> rdy_r || !clkEn
            || ctlWrite;
    endproperty
    a_rdy_holds: assert property (p_rdy_holds)
        else $error("read window closed early");
    property p_busy_on_write;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && !busy && wrAcc && isAddr(paddr, OFF_SECONDS)) |=> busy;
    endproperty
    a_busy_on_write: assert property (p_busy_on_write)
        else $error("busy not raised by counter write");
    property p_busy_ends;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && $rose(busy)) |-> ##[1:8] !busy || !clkEn;
    endproperty
    a_busy_ends: assert property (p_busy_ends)
        else $error("busy stuck high");
    property p_osc_locked;
        @(posedge clk) disable iff (!reset_n)
        (!wrEn_r) |=> $stable(oscCtrl_r);
    endproperty
    a_osc_locked: assert property (p_osc_locked)
        else $error("locked oscillator control changed");
    property p_tod_sets;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && todMatch && !todMatchPrev_r && enable_r) |=> todFlag_r;
    endproperty
    a_tod_sets: assert property (p_tod_sets)
        else $error("daytime alarm flag not set on match");
    property p_int_reload;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && intWrap) |=> (ssFlag_r && intCount_r == $past(intStart_r));
    endproperty
    a_int_reload: assert property (p_int_reload)
        else $error("interval alarm did not flag and reload");
    property p_irq_needs_enable;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && !irqSystemEnable) |=> !clockIrqLine;
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
        else $error("interrupt raised without system enable");
endmodule : rcac_core
`default_nettype wire

/* rtl/rcac_pkg.sv */
// Package for the real-time clock counter and alarm core
package rcac_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] OFF_SECONDS = 8'h00;
    localparam logic [7:0] OFF_SUBSEC = 8'h04;
    localparam logic [7:0] OFF_DAYALARM = 8'h08;
    localparam logic [7:0] OFF_INTALARM = 8'h0c;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_TRIM = 8'h14;
    localparam logic [7:0] OFF_OSCCTRL = 8'h18;
    // Control register field positions
    localparam int CTL_EN = 0;
    localparam int CTL_TODIE = 1;
    localparam int CTL_SSIE = 2;
    localparam int CTL_BUSY = 3;
    localparam int CTL_RDY = 4;
    localparam int CTL_RDYIE = 5;
    localparam int CTL_TODFLAG = 6;
    localparam int CTL_SSFLAG = 7;
    localparam int CTL_RDEN = 14;
    localparam int CTL_WREN = 15;
    // Widths
    localparam int SUB_W = 12;
    localparam int TOD_W = 20;
    localparam int TRIM_W = 8;
    localparam int TICK_W = 24;
    localparam int OSC_W = 8;
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int TICK_HZ = 4096;
    localparam int TICK_DIV_W = 4;
    localparam int TICK_DIV_LAST = 7; // 32768 / 4096 = 8 osc edges
    localparam int RDY_TIME_US = 120;
    localparam int RDY_CYCLES = (RDY_TIME_US * (CLK_HZ / 1000000));
    localparam int RDY_W = 12;
    localparam int TRIM_SECS = 32;
    localparam int TRIM_SEC_W = 5;
    localparam int SYNC_CYCLES = 2;
    localparam logic [31:0] ALL_ONES = 32'hffffffff;
    localparam logic [SUB_W-1:0] SUB_ONES = 12'hfff;
    // Pending write kinds waiting for the busy count to complete
    typedef enum logic [2:0] {
        WK_NONE = 3'b000,
        WK_SEC = 3'b001,
        WK_SUB = 3'b010,
        WK_TOD = 3'b011,
        WK_INT = 3'b100,
        WK_TRIM = 3'b101,
        WK_EN = 3'b110
    } rcac_wkind_t;
    // Pending write carrier
    typedef struct packed {
        rcac_wkind_t kind;
        logic [31:0] data;
    } rcac_pend_t;
endpackage : rcac_pkg

/* sim/rcac_core_test.sv */
// Self-checking bench for the clock counter and alarm core over APB
`timescale 1ns/100ps
`default_nettype none
module rcac_core_test;
    import rcac_pkg::*;
    // Time base runs faster than a real crystal so ticks fit in the run
    localparam int OSC_HALF = 200;
    localparam int TICK_CYC = 16 * OSC_HALF;
    localparam int CEIL = 90000;
    localparam logic [31:0] M_EN = 32'h1 << CTL_EN;
    localparam logic [31:0] M_TODIE = 32'h1 << CTL_TODIE;
    localparam logic [31:0] M_SSIE = 32'h1 << CTL_SSIE;
    localparam logic [31:0] M_BUSY = 32'h1 << CTL_BUSY;
    localparam logic [31:0] M_RDY = 32'h1 << CTL_RDY;
    localparam logic [31:0] M_RDYIE = 32'h1 << CTL_RDYIE;
    localparam logic [31:0] M_TODF = 32'h1 << CTL_TODFLAG;
    localparam logic [31:0] M_SSF = 32'h1 << CTL_SSFLAG;
    localparam logic [31:0] M_RDEN = 32'h1 << CTL_RDEN;
    localparam logic [31:0] M_WREN = 32'h1 << CTL_WREN;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic oscInputPin = 1'b0;
    logic irqSystemEnable = 1'b0;
    logic clockWakeAllow = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic clockIrqLine;
    logic wakeRequest;
    int failCount = 0;
    int samplesChecked = 0;
    int cycles = 0;
    logic [31:0] q;
    logic [31:0] base;
    int t0;
    int t1;

    rcac_core dut (
        .clk(clk),
        .reset_n(reset_n),
        .clkEn(1'b1),
        .oscInputPin(oscInputPin),
        .irqSystemEnable(irqSystemEnable),
        .clockWakeAllow(clockWakeAllow),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .clockIrqLine(clockIrqLine),
        .wakeRequest(wakeRequest)
    );

    // Clock at 25 MHz
    always #20 clk = ~clk;

    // Time base, cycle count and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles % OSC_HALF == OSC_HALF - 1) begin
            oscInputPin <= ~oscInputPin;
        end
        if (cycles >= CEIL) begin
            failCount++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (failCount == 0 && samplesChecked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            failCount++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One transfer; the bus stays selected so another may follow at once
    task automatic apb(input logic dir, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= dir;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // No wait limit here; the cycle ceiling ends a hung transfer
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata;
        chk("pslverr", 32'h0, {31'h0, pslverr});
    endtask : apb

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : idle

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
        idle();
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r);
        idle();
    endtask : rd_reg

    // Repeated reads until a masked field matches, bounded
    task automatic poll(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e, input int lim, output int t);
        logic [31:0] r;
        int n;
        n = 0;
        rd_reg(a, r);
        while ((r & m) !== e && n < lim) begin
            n++;
            rd_reg(a, r);
        end
        t = cycles;
        chk("poll", e, r & m);
    endtask : poll

    task automatic wait_idle();
        int t;
        poll(OFF_CONTROL, M_BUSY, 32'h0, 20, t);
    endtask : wait_idle

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (clockIrqLine !== 1'b1 && n < 12000) begin
            n++;
            @(posedge clk);
        end
        t = cycles;
        chk("irq rise", 32'h1, {31'h0, clockIrqLine});
    endtask : wait_irq

    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd_reg(OFF_CONTROL, q);
        chk("control reset", 32'h0, q);
        rd_reg(8'h1c, q);
        chk("unmapped", 32'h0, q);
        // Enable and oscillator writes without unlock are dropped
        wr_reg(OFF_CONTROL, M_EN);
        wait_idle();
        rd_reg(OFF_CONTROL, q);
        chk("enable locked", 32'h0, q & M_EN);
        wr_reg(OFF_TRIM, 32'h11);
        rd_reg(OFF_TRIM, q);
        chk("trim locked", 32'h0, q);
        rd_reg(OFF_OSCCTRL, base);
        wr_reg(OFF_OSCCTRL, 32'ha5);
        rd_reg(OFF_OSCCTRL, q);
        chk("osc locked", base, q);
        wr_reg(OFF_CONTROL, M_WREN | M_RDEN);
        wait_idle();
        apb(1'b1, OFF_OSCCTRL, 32'h5a, q);
        apb(1'b0, OFF_CONTROL, 32'h0, q);
        idle();
        chk("osc no busy", 32'h0, q & M_BUSY);
        rd_reg(OFF_OSCCTRL, q);
        chk("osc", 32'h5a, q);
        wr_reg(OFF_TRIM, 32'h3c);
        wait_idle();
        rd_reg(OFF_TRIM, q);
        chk("trim", 32'h3c, q);
        // Back-to-back counter writes: the second meets busy
        apb(1'b1, OFF_SUBSEC, 32'hffe, q);
        apb(1'b1, OFF_SECONDS, 32'h77, q);
        idle();
        wait_idle();
        rd_reg(OFF_SECONDS, q);
        chk("seconds dropped", 32'h0, q);
        rd_reg(OFF_SUBSEC, q);
        chk("subsec", 32'hffe, q);
        apb(1'b1, OFF_SECONDS, 32'h5, q);
        apb(1'b0, OFF_CONTROL, 32'h0, q);
        idle();
        chk("busy", M_BUSY, q & M_BUSY);
        wait_idle();
        wr_reg(OFF_DAYALARM, 32'h6);
        wait_idle();
        rd_reg(OFF_DAYALARM, q);
        chk("day alarm", 32'h6, q);
        repeat (8000) @(posedge clk);
        rd_reg(OFF_SUBSEC, q);
        chk("frozen", 32'hffe, q);
        // Run: two ticks carry seconds from 5 to 6, matching the alarm
        wr_reg(OFF_CONTROL, M_WREN | M_RDEN | M_EN | M_TODIE);
        wait_idle();
        poll(OFF_SECONDS, 32'hffffffff, 32'h6, 4000, t0);
        rd_reg(OFF_SUBSEC, q);
        chk("subsec wrap", 32'h0, q);
        rd_reg(OFF_CONTROL, q);
        chk("day flag", M_TODF, q & M_TODF);
        wr_reg(OFF_DAYALARM, 32'h9);
        rd_reg(OFF_DAYALARM, q);
        chk("day alarm locked", 32'h6, q);
        chk("irq gated", 32'h0, {31'h0, clockIrqLine});
        irqSystemEnable <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq", 32'h1, {31'h0, clockIrqLine});
        chk("wake gated", 32'h0, {31'h0, wakeRequest});
        clockWakeAllow <= 1'b1;
        repeat (3) @(posedge clk);
        chk("wake", 32'h1, {31'h0, wakeRequest});
        wr_reg(OFF_CONTROL, M_WREN | M_RDEN | M_EN);
        wait_idle();
        @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, clockIrqLine});
        // Interval alarm: two ticks from start value to wrap
        wr_reg(OFF_INTALARM, 32'hfffffffe);
        wait_idle();
        rd_reg(OFF_INTALARM, q);
        chk("interval", 32'hfffffffe, q);
        wr_reg(OFF_CONTROL, M_WREN | M_RDEN | M_EN | M_SSIE);
        wait_idle();
        wait_irq(t0);
        rd_reg(OFF_CONTROL, q);
        chk("interval flag", M_SSF, q & M_SSF);
        wr_reg(OFF_INTALARM, 32'h1);
        rd_reg(OFF_INTALARM, q);
        chk("interval locked", 32'hfffffffe, q);
        wr_reg(OFF_CONTROL, M_WREN | M_RDEN | M_EN | M_SSIE);
        wait_idle();
        chk("flag cleared", 32'h0, {31'h0, clockIrqLine});
        wait_irq(t1);
        chk("reload period", 2 * TICK_CYC, t1 - t0);
        rd_reg(OFF_CONTROL, q);
        chk("day once", 32'h0, q & M_TODF);
        // Read window: cleared, set by next update, then closes
        wr_reg(OFF_CONTROL, M_WREN | M_EN);
        wait_idle();
        rd_reg(OFF_CONTROL, q);
        chk("ready cleared", 32'h0, q & M_RDY);
        poll(OFF_CONTROL, M_RDY, M_RDY, 2000, t0);
        rd_reg(OFF_SECONDS, q);
        chk("window read", 32'h6, q);
        poll(OFF_CONTROL, M_RDY, 32'h0, 2000, t1);
        rd_reg(OFF_SECONDS, q);
        chk("window closed", 32'h0, q);
        chk("window", 32'h1, {31'h0, (t1 - t0 >= RDY_CYCLES - 6)
            && (t1 - t0 <= RDY_CYCLES + 6)});
        wr_reg(OFF_CONTROL, M_WREN | M_EN | M_RDYIE);
        wait_irq(t0);
        wrap_up();
    end
endmodule : rcac_core_test
`default_nettype wire
